// ### core/add_ops_consts.vh
// Purpose: Constants for the add-group execution datapath
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: Offsets are byte addresses
//
// What this block does
// RULE_01 - Memory add reads the word, adds the accumulator, writes the sum back.
// RULE_02 - Negative flag follows bit 31 of the result.
// RULE_03 - Zero flag is set only when the 32-bit result is zero.
// RULE_04 - Carry flag follows the carry out of bit 31.
// RULE_05 - Overflow flag is sticky: set on overflow, else unchanged.
// RULE_06 - Without saturation, signed counter counts up on positive, down on negative overflow.
// RULE_07 - With saturation, overflowing signed accumulator add loads the largest or most negative value.
// RULE_08 - Memory, product and aux adds clear the repeat count and run once.
// RULE_09 - Word and unsigned accumulator adds run N+1 times; overflow flag gathers all.
// RULE_10 - Repeated word add updates the signed counter on every overflow when saturation is off.
// RULE_11 - Word add zero-extends the 16-bit operand before adding.
// RULE_12 - Product add puts the unsigned sum into the product register.
// RULE_13 - Product add flags follow the product register result.
// RULE_14 - Unsigned adds bump the carry counter on carry, whatever the saturation mode.
// RULE_15 - Unsigned accumulator add works only in object compatibility mode.
// RULE_16 - Repeated unsigned accumulator add counts every carry.
// RULE_17 - Aux add zero-extends eight bits into the selected aux register, no flags.
// RULE_18 - Three-bit pointer picks one of eight aux registers.
// RULE_19 - Signed overflow: equal operand signs, result sign differs.
// RULE_20 - Memory add applies flags and saturation to the written sum.
`ifndef ADD_OPS_CONSTS_VH
`define ADD_OPS_CONSTS_VH
`define REG_CTRL 12'h000
`define REG_OPND 12'h004
`define REG_MEMW 12'h008
`define REG_ACC 12'h00c
`define REG_PROD 12'h010
`define REG_STAT 12'h014
`define REG_OVC 12'h018
`define REG_UNSIGNED_CARRY_COUNTER 12'h01c
`define REG_REPEAT_COUNT_REG 12'h020
`define REG_CMD 12'h024
`define REG_AUX0 12'h040
`define CTRL_SAT 0
`define CTRL_OBJ 1
`define CTRL_ARP_LO 4
`define ST_N 0
`define ST_Z 1
`define ST_C 2
`define ST_V 3
`define ST_BUSY 4
`define ST_ILL 5
`define OP_ADD_LONG_OP_MEM 3'h1
`define OP_ADD_UNSIGNED_WORD_OP 3'h2
`define OP_ADD_UNSIGNED_LONG_OP_P 3'h3
`define OP_ADD_UNSIGNED_LONG_OP_ACC 3'h4
`define OP_AUX_IMMEDIATE_ADD_OP 3'h5
`define SAT_POS 32'h7fffffff
`define SAT_NEG 32'h80000000
`define CTRL_RESET 32'h00000002
`endif

// ### core/add_ops.v
// Purpose: Add-group execution datapath with APB register access
// Assumes: Operand words are written by software before the command
// Notes: One-wait APB, writes land with pready, pslverr on unmapped addresses
//
// Implementation choices: the APB slave port and the placing of the registers.
`include "add_ops_consts.vh"
module add_ops #(
    parameter AUX_COUNT = 8,
    parameter CNT_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg busy
);
////////////////////////////////////////////////////////////////////////
reg [31:0] ctrl;
reg [31:0] opnd;
reg [31:0] mem_word;
reg [31:0] main_sum_reg;
reg [31:0] mult_result_reg;
reg [5:0] stat;
reg [CNT_W-1:0] signed_overflow_counter;
reg [CNT_W-1:0] unsigned_carry_counter;
reg [15:0] repeat_count_reg;
reg [2:0] op;
reg [15:0] iter;
reg [31:0] aux_reg_n [0:AUX_COUNT-1];
wire saturate_mode_bit = ctrl[`CTRL_SAT];
wire object_compat_mode = ctrl[`CTRL_OBJ];
wire [2:0] aux_pointer_sel = ctrl[`CTRL_ARP_LO+2:`CTRL_ARP_LO]; // RULE_18
wire wr = psel & penable & pwrite & pready;
wire start = wr & (paddr == `REG_CMD) & ~busy;
////////////////////////////////////////////////////////////////////////
// Operand and sum selection
reg [31:0] a;
reg [31:0] b;
reg [32:0] sum;
reg ovf;
reg pos_ovf;
reg signed_op;
always @* begin
    a = main_sum_reg;
    b = mem_word;
    signed_op = 1'b1;
    case (op)
        `OP_ADD_UNSIGNED_WORD_OP: b = {16'h0000, opnd[15:0]}; // RULE_11
        `OP_ADD_UNSIGNED_LONG_OP_P: begin
            a = mult_result_reg;
            signed_op = 1'b0;
        end
        `OP_ADD_UNSIGNED_LONG_OP_ACC: signed_op = 1'b0;
        default: signed_op = 1'b1;
    endcase
    sum = {1'b0, a} + {1'b0, b};
    ovf = (a[31] == b[31]) && (sum[31] != a[31]); // RULE_19
    pos_ovf = ovf & ~a[31];
end
reg [31:0] res;
always @* begin
    res = sum[31:0];
    if (signed_op && ovf && saturate_mode_bit) begin
        res = pos_ovf ? `SAT_POS : `SAT_NEG; // RULE_07 RULE_20
    end
end
////////////////////////////////////////////////////////////////////////
// Execution
integer k;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl <= `CTRL_RESET;
        opnd <= 32'h00000000;
        mem_word <= 32'h00000000;
        main_sum_reg <= 32'h00000000;
        mult_result_reg <= 32'h00000000;
        stat <= 6'h00;
        signed_overflow_counter <= {CNT_W{1'b0}};
        unsigned_carry_counter <= {CNT_W{1'b0}};
        repeat_count_reg <= 16'h0000;
        op <= 3'h0;
        iter <= 16'h0000;
        busy <= 1'b0;
        for (k = 0; k < AUX_COUNT; k = k + 1) begin
            aux_reg_n[k] <= 32'h00000000;
        end
    end else if (clk_en) begin
        if (wr && !busy) begin
            case (paddr)
                `REG_CTRL: ctrl <= pwdata;
                `REG_OPND: opnd <= pwdata;
                `REG_MEMW: mem_word <= pwdata;
                `REG_ACC: main_sum_reg <= pwdata;
                `REG_PROD: mult_result_reg <= pwdata;
                `REG_STAT: stat <= pwdata[5:0];
                `REG_OVC: signed_overflow_counter <= pwdata[CNT_W-1:0];
                `REG_UNSIGNED_CARRY_COUNTER: unsigned_carry_counter <= pwdata[CNT_W-1:0];
                `REG_REPEAT_COUNT_REG: repeat_count_reg <= pwdata[15:0];
                default: ;
            endcase
            if (paddr >= `REG_AUX0 && paddr < `REG_AUX0 + 4 * AUX_COUNT) begin
                aux_reg_n[paddr[4:2]] <= pwdata;
            end
        end
        if (start) begin
            op <= pwdata[2:0];
            stat[`ST_ILL] <= 1'b0;
            case (pwdata[2:0])
                `OP_ADD_UNSIGNED_WORD_OP: begin
                    busy <= 1'b1; // RULE_09
                    iter <= repeat_count_reg;
                    repeat_count_reg <= 16'h0000;
                end
                `OP_ADD_UNSIGNED_LONG_OP_ACC: begin
                    if (object_compat_mode) begin
                        busy <= 1'b1; // RULE_15 RULE_09
                        iter <= repeat_count_reg;
                    end else begin
                        stat[`ST_ILL] <= 1'b1; // RULE_15
                    end
                    repeat_count_reg <= 16'h0000;
                end
                `OP_ADD_LONG_OP_MEM, `OP_ADD_UNSIGNED_LONG_OP_P, `OP_AUX_IMMEDIATE_ADD_OP: begin
                    busy <= 1'b1;
                    iter <= 16'h0000;
                    repeat_count_reg <= 16'h0000; // RULE_08
                end
                default: stat[`ST_ILL] <= 1'b1;
            endcase
        end
        if (busy) begin
            if (iter == 16'h0000) begin
                busy <= 1'b0;
            end else begin
                iter <= iter - 16'h0001;
            end
            if (op == `OP_AUX_IMMEDIATE_ADD_OP) begin
                aux_reg_n[aux_pointer_sel] <= aux_reg_n[aux_pointer_sel] + {24'h000000, opnd[7:0]}; // RULE_17
            end else begin
                case (op)
                    `OP_ADD_LONG_OP_MEM: mem_word <= res; // RULE_01 RULE_20
                    `OP_ADD_UNSIGNED_LONG_OP_P: mult_result_reg <= sum[31:0]; // RULE_12
                    default: main_sum_reg <= res;
                endcase
                stat[`ST_N] <= (op == `OP_ADD_UNSIGNED_LONG_OP_P) ? sum[31] : res[31]; // RULE_02 RULE_13
                stat[`ST_Z] <= ((op == `OP_ADD_UNSIGNED_LONG_OP_P) ? sum[31:0] : res) == 32'h00000000; // RULE_03 RULE_13
                stat[`ST_C] <= sum[32]; // RULE_04
                if (ovf) begin
                    stat[`ST_V] <= 1'b1; // RULE_05 RULE_09
                end
                if (signed_op && ovf && !saturate_mode_bit) begin
                    if (pos_ovf) begin
                        signed_overflow_counter <= signed_overflow_counter + 1'b1; // RULE_06 RULE_10
                    end else begin
                        signed_overflow_counter <= signed_overflow_counter - 1'b1; // RULE_06 RULE_10
                    end
                end
                if (!signed_op && sum[32]) begin
                    unsigned_carry_counter <= unsigned_carry_counter + 1'b1; // RULE_14 RULE_16
                end
            end
        end
    end
end
////////////////////////////////////////////////////////////////////////
// APB slave
wire mapped = (paddr <= `REG_CMD && paddr[1:0] == 2'b00) ||
    (paddr >= `REG_AUX0 && paddr < `REG_AUX0 + 4 * AUX_COUNT && paddr[1:0] == 2'b00);
reg [31:0] rd;
always @* begin
    rd = 32'h00000000;
    case (paddr)
        `REG_CTRL: rd = ctrl;
        `REG_OPND: rd = opnd;
        `REG_MEMW: rd = mem_word;
        `REG_ACC: rd = main_sum_reg;
        `REG_PROD: rd = mult_result_reg;
        `REG_STAT: rd = {26'h0000000, stat[5], busy, stat[3:0]};
        `REG_OVC: rd = signed_overflow_counter;
        `REG_UNSIGNED_CARRY_COUNTER: rd = unsigned_carry_counter;
        `REG_REPEAT_COUNT_REG: rd = {16'h0000, repeat_count_reg};
        `REG_CMD: rd = {29'h00000000, op};
        default: rd = 32'h00000000;
    endcase
    if (paddr >= `REG_AUX0 && paddr < `REG_AUX0 + 4 * AUX_COUNT) begin
        rd = aux_reg_n[paddr[4:2]];
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else if (clk_en) begin
        pready <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~mapped;
        if (psel && penable && !pready && !pwrite) begin
            prdata <= mapped ? rd : 32'h00000000;
        end
    end
end
endmodule

// ### dv/add_ops_asserts.sv
// Purpose: Port checks for add_ops
// Assumes: clk_en high
// Notes: Bound below
`include "add_ops_consts.vh"
module add_ops_asserts (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] repeat_prefix;
    logic [16:0] n;
    logic [16:0] it;
    wire take = psel && penable && pready && pwrite && !busy;
    wire go = take && paddr == `REG_CMD;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_prefix <= 16'h0;
            n <= 17'h0;
            it <= 17'h0;
        end else begin
            n <= busy ? n + 17'h1 : 17'h0;
            if (take && paddr == `REG_REPEAT_COUNT_REG) repeat_prefix <= pwdata[15:0];
            if (go) repeat_prefix <= 16'h0;
            if (go) it <= (pwdata == 32'h2) ? {1'b0, repeat_prefix} + 17'h1 : {16'h0, pwdata != 32'h4};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_lat; psel && penable && !pready |=> pready; endproperty
    a_lat: assert property (p_lat) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_rdy; pready |-> $past(psel && penable); endproperty
    a_rdy: assert property (p_rdy) else $error("pready unasked");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    property p_erd; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_erd: assert property (p_erd) else $error("error read data");
    property p_rst; $rose(presetn) |-> !pready && !busy; endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    property p_start; go && pwdata inside {32'h1, 32'h2, 32'h3, 32'h5} |=> busy; endproperty
    a_start: assert property (p_start) else $error("command not started");
    property p_iter; $fell(busy) && it != 17'h0 |-> n == it; endproperty
    a_iter: assert property (p_iter) else $error("iteration count");
endmodule
bind add_ops add_ops_asserts chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

// ### dv/apb_host.sv
// Purpose: APB host facing add_ops
// Assumes: One access at a time
// Notes: Flags a wait over 20 edges
module apb_host (
    input wire pclk,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h0,
    output logic [31:0] pwdata = 32'h0,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e, output logic t);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        t = pready !== 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ### dv/test_add_ops.sv
// Purpose: Self-checking bench for add_ops
// Assumes: Host model drives the bus
// Notes: Table rows, then hand tests
`include "add_ops_consts.vh"
module test_add_ops;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, busy;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    int fails = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er;
    logic to;
    // Ctrl acc memw opnd repeat_count_reg cmd addr result stat ovc unsigned_carry_counter
    logic [31:0] tbl [9][11] = '{
        '{32'h2, 32'h1, 32'hffffffff, 32'h0, 32'h0, 32'h1, 32'h8, 32'h0, 32'h6, 32'h0, 32'h0},
        '{32'h3, 32'h7fffffff, 32'h1, 32'h0, 32'h0, 32'h1, 32'h8, 32'h7fffffff, 32'h8, 32'h0, 32'h0},
        '{32'h2, 32'h80000000, 32'h80000000, 32'h0, 32'h0, 32'h1, 32'h8, 32'h0, 32'he, 32'hffffffff, 32'h0},
        '{32'h2, 32'h7fff0000, 32'h0, 32'hffff8000, 32'h2, 32'h2, 32'hc, 32'h80008000, 32'h9, 32'h0, 32'h0},
        '{32'h3, 32'hffffffff, 32'h1, 32'h0, 32'h3, 32'h3, 32'h10, 32'h0, 32'h6, 32'h0, 32'h1},
        '{32'h2, 32'hffffffff, 32'hffffffff, 32'h0, 32'h1, 32'h4, 32'hc, 32'hfffffffd, 32'h5, 32'h0, 32'h3},
        '{32'h52, 32'h0, 32'h0, 32'h1ff, 32'h0, 32'h5, 32'h54, 32'hff, 32'h0, 32'h0, 32'h3},
        '{32'h0, 32'h5, 32'h1, 32'h0, 32'h0, 32'h4, 32'hc, 32'h5, 32'h20, 32'h0, 32'h3},
        '{32'h72, 32'h0, 32'h0, 32'h80, 32'h0, 32'h5, 32'h5c, 32'h80, 32'h0, 32'h0, 32'h3}};
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    add_ops dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rd, er, to);
        check("timeout", {31'h0, to}, 32'h0);
        if (to) complete_run();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    task automatic wait_idle();
        int k = 0;
        do begin
            bus(1'b0, `REG_STAT, 32'h0);
            k++;
        end while (rd[`ST_BUSY] !== 1'b0 && k < 50);
        check("idle", {31'h0, rd[`ST_BUSY]}, 32'h0);
        if (rd[`ST_BUSY] !== 1'b0) complete_run();
        check("busy pin", {31'h0, busy}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", `REG_CTRL, 32'h2);
        rdc("unmapped", 12'h030, 32'h0);
        check("slverr", {31'h0, er}, 32'h1);
        foreach (tbl[i]) begin
            wr(`REG_CTRL, tbl[i][0]);
            wr(`REG_ACC, tbl[i][1]);
            wr(`REG_PROD, tbl[i][1]);
            wr(`REG_MEMW, tbl[i][2]);
            wr(`REG_OPND, tbl[i][3]);
            wr(`REG_REPEAT_COUNT_REG, tbl[i][4]);
            wr(`REG_STAT, 32'h0);
            wr(`REG_CMD, tbl[i][5]);
            wait_idle();
            rdc("res", tbl[i][6][11:0], tbl[i][7]);
            rdc("stat", `REG_STAT, tbl[i][8]);
            rdc("ovc", `REG_OVC, tbl[i][9]);
            rdc("unsigned_carry_counter", `REG_UNSIGNED_CARRY_COUNTER, tbl[i][10]);
            $display("row %0d done", i);
        end
        wr(`REG_REPEAT_COUNT_REG, 32'h4);
        wr(`REG_CMD, {29'h0, `OP_AUX_IMMEDIATE_ADD_OP});
        wait_idle();
        rdc("repeat_count_reg", `REG_REPEAT_COUNT_REG, 32'h0);
        rdc("aux once", 12'h05c, 32'h100);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl after reset", `REG_CTRL, 32'h2);
        rdc("acc after reset", `REG_ACC, 32'h0);
        rdc("aux after reset", 12'h05c, 32'h0);
        $display("hand tests done");
        complete_run();
    end
endmodule
